//--- hw/hpap_pkg.sv
// constants, types and byte helpers for the host palette access port
// assumes a single 40 MHz clock domain and a byte-wide host register bus
package hpap_pkg;

   // ---------------------------------------------------------------
   // widths and sizes
   // ---------------------------------------------------------------
   localparam int DATA_W    = 8;                 // host data byte
   localparam int SEL_W     = 3;                 // register select width
   localparam int ADDR_W    = 8;                 // palette address width
   localparam int PAL_DEPTH = 256;               // palette entries
   localparam int COLOR_W   = 24;                // red, green, blue bytes
   localparam int IDX_W     = 11;                // index pointer width
   localparam int IDX_HI_W  = 3;                 // index bits in high byte
   localparam int SYNC_W    = 13;                // wr_n, rd_n, select, data

   // ---------------------------------------------------------------
   // register select codes
   // ---------------------------------------------------------------
   localparam logic [2:0] SEL_PAL_WADDR = 3'h0;  // address, write mode
   localparam logic [2:0] SEL_PAL_DATA  = 3'h1;  // palette data port
   localparam logic [2:0] SEL_PIX_MASK  = 3'h2;  // pixel mask
   localparam logic [2:0] SEL_PAL_RADDR = 3'h3;  // address, read mode
   localparam logic [2:0] SEL_IDX_LOW   = 3'h4;  // index pointer low
   localparam logic [2:0] SEL_IDX_HIGH  = 3'h5;  // index pointer high
   localparam logic [2:0] SEL_IDX_DATA  = 3'h6;  // indexed data port
   localparam logic [2:0] SEL_IDX_CTL   = 3'h7;  // index auto-increment control
   localparam int         SCHEME_BIT    = 2;     // select bit picking the scheme
   localparam logic       SCHEME_VGA    = 1'b0;  // value of that bit for vga

   // ---------------------------------------------------------------
   // reset values and constants
   // ---------------------------------------------------------------
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [7:0]  ADDR_STEP     = 8'h01;
   localparam logic [7:0]  PAL_ADDR_RST  = 8'h00;
   localparam logic [7:0]  PIX_MASK_RST  = 8'hFF;
   localparam logic [7:0]  IDX_CTL_RST   = 8'h00;
   localparam logic [10:0] IDX_RST       = 11'h000;
   localparam logic [10:0] IDX_STEP      = 11'h001;
   localparam int          IDX_AUTOINC   = 0;    // auto-increment bit
   localparam logic [7:0]  STATUS_WRITE  = 8'h00;
   localparam logic [7:0]  STATUS_READ   = 8'h03;
   localparam logic        COLRES_6BIT   = 1'b0; // resolution select, 6-bit
   localparam logic [12:0] SYNC_RST      = 13'h1800; // strobes idle high

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic {
      PM_WRITE = 1'b0,
      PM_READ  = 1'b1
   } hpap_mode_type;

   typedef enum logic [1:0] {
      COMP_RED   = 2'b00,
      COMP_GREEN = 2'b01,
      COMP_BLUE  = 2'b10
   } hpap_comp_type;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // palette address step, wraps at the top
   function automatic logic [7:0] addr_inc(input logic [7:0] a);
      addr_inc = a + ADDR_STEP;
   endfunction

   // host byte into a holding byte
   function automatic logic [7:0] host_to_held(input logic [7:0] d, input logic res);
      host_to_held = (res == COLRES_6BIT) ? {d[5:0], 2'b00} : d;
   endfunction

   // holding byte onto the host bus
   function automatic logic [7:0] held_to_host(input logic [7:0] h, input logic res);
      held_to_host = (res == COLRES_6BIT) ? {2'b00, h[7:2]} : h;
   endfunction

endpackage

//--- hw/hpap_sync2.sv
// two-stage synchroniser for a bundle of pin inputs
// assumes the bundle is sampled on mclk with a synchronous active-low reset
`timescale 1ns/1ps
module hpap_sync2 #(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;    // first stage, read only by q

   // two flops, reset to the idle level
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         meta_reg <= RST;
         q        <= RST;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule

//--- hw/hpap_palette_ram.sv
// 256 x 24 colour palette, one write port, host and pixel read ports
// assumes synchronous reads with one cycle of latency on mclk
`timescale 1ns/1ps
module hpap_palette_ram (
   input  wire logic                          mclk,
   input  wire logic                          wr_en,
   input  wire logic [hpap_pkg::ADDR_W-1:0]   wr_addr,
   input  wire logic [hpap_pkg::COLOR_W-1:0]  wr_data,
   input  wire logic                          rd_en,
   input  wire logic [hpap_pkg::ADDR_W-1:0]   rd_addr,
   output logic      [hpap_pkg::COLOR_W-1:0]  rd_data,
   input  wire logic [hpap_pkg::ADDR_W-1:0]   pix_addr,
   output logic      [hpap_pkg::COLOR_W-1:0]  pix_data
);
   import hpap_pkg::*;

   logic [COLOR_W-1:0] mem [PAL_DEPTH];   // whole entry per word

   // one write and two registered reads per cycle
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
      pix_data <= mem[pix_addr];
   end
endmodule

//--- hw/hpap_host_port.sv
// host access port: vga palette scheme and indexed scheme behind one select
// assumes asynchronous host strobes (synchronised here) and an indexed
// register file outside that answers idx_rdata combinationally from idx_addr
`timescale 1ns/1ps
module hpap_host_port (
   input  wire logic                          mclk,
   input  wire logic                          nrst,
   input  wire logic [hpap_pkg::SEL_W-1:0]    reg_select,
   input  wire logic                          host_wr_n,
   input  wire logic                          host_rd_n,
   input  wire logic [hpap_pkg::DATA_W-1:0]   host_data_in,
   output logic      [hpap_pkg::DATA_W-1:0]   host_data_out,
   output logic                               host_data_oe,
   input  wire logic                          color_resolution_sel,
   input  wire logic                          read_addr_status_fmt,
   output logic      [hpap_pkg::DATA_W-1:0]   pixel_mask,
   input  wire logic [hpap_pkg::ADDR_W-1:0]   pixel_index,
   output logic      [hpap_pkg::COLOR_W-1:0]  pixel_color,
   output logic      [hpap_pkg::IDX_W-1:0]    idx_addr,
   output logic      [hpap_pkg::DATA_W-1:0]   idx_wdata,
   output logic                               idx_wr,
   output logic                               idx_rd,
   input  wire logic [hpap_pkg::DATA_W-1:0]   idx_rdata
);
   import hpap_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                wr_prev;     // last synced write strobe
      logic                rd_prev;     // last synced read strobe
      hpap_mode_type       mode;        // palette write or read mode
      hpap_comp_type       comp;        // next colour byte
      logic                load_pend;   // palette read data due
      logic [ADDR_W-1:0]   pal_addr;    // shared palette address
      logic [7:0]          red;         // holding bytes
      logic [7:0]          green;
      logic [7:0]          blue;
      logic [DATA_W-1:0]   pix_mask;    // pixel mask
      logic [IDX_W-1:0]    idx_ptr;     // index pointer
      logic [DATA_W-1:0]   idx_ctl;     // auto-increment control
      logic [DATA_W-1:0]   idx_wdata;   // indexed write byte
      logic                idx_wr;      // indexed write pulse
      logic                idx_rd;      // indexed read pulse
      logic [DATA_W-1:0]   dout;        // host read byte
      logic                doe;         // host bus drive
   } hpap_state_type;

   localparam hpap_state_type ST_RST = '{
      wr_prev: 1'b1, rd_prev: 1'b1, mode: PM_WRITE, comp: COMP_RED,
      load_pend: 1'b0, pal_addr: PAL_ADDR_RST, red: BYTE_ZERO,
      green: BYTE_ZERO, blue: BYTE_ZERO, pix_mask: PIX_MASK_RST,
      idx_ptr: IDX_RST, idx_ctl: IDX_CTL_RST, idx_wdata: BYTE_ZERO,
      idx_wr: 1'b0, idx_rd: 1'b0, dout: BYTE_ZERO, doe: 1'b0};

   hpap_state_type st_reg;                 // registered state
   hpap_state_type st_next;                // next state
   logic [SYNC_W-1:0]  sync_q;             // synchronised pins
   logic               s_wr_n;             // synced write strobe
   logic               s_rd_n;             // synced read strobe
   logic [SEL_W-1:0]   s_sel;              // synced register select
   logic [DATA_W-1:0]  s_din;              // synced host data
   logic               wr_ev;              // end of a host write
   logic               rd_begin;           // start of a host read
   logic               rd_end;             // end of a host read
   logic               ram_we;             // palette store
   logic [COLOR_W-1:0] ram_wdata;          // palette store word
   logic               ram_re;             // palette load
   logic [ADDR_W-1:0]  ram_raddr;          // palette load address
   logic [COLOR_W-1:0] ram_rdata;          // palette load word

   // ---------------------------------------------------------------
   // pin synchronisation and strobe edges
   // ---------------------------------------------------------------
   hpap_sync2 #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .d    ({host_wr_n, host_rd_n, reg_select, host_data_in}),
      .q    (sync_q)
   );

   assign {s_wr_n, s_rd_n, s_sel, s_din} = sync_q;
   assign wr_ev    = !st_reg.wr_prev && s_wr_n;     // rising write strobe
   assign rd_begin = st_reg.rd_prev && !s_rd_n;     // falling read strobe
   assign rd_end   = !st_reg.rd_prev && s_rd_n;     // rising read strobe

   // ---------------------------------------------------------------
   // palette storage
   // ---------------------------------------------------------------
   hpap_palette_ram u_ram (
      .mclk     (mclk),
      .wr_en    (ram_we),
      .wr_addr  (st_reg.pal_addr),
      .wr_data  (ram_wdata),
      .rd_en    (ram_re),
      .rd_addr  (ram_raddr),
      .rd_data  (ram_rdata),
      .pix_addr (pixel_index),
      .pix_data (pixel_color)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next         = st_reg;
      st_next.wr_prev = s_wr_n;
      st_next.rd_prev = s_rd_n;
      st_next.idx_wr  = 1'b0;
      st_next.idx_rd  = 1'b0;
      ram_we          = 1'b0;
      ram_wdata       = {st_reg.red, st_reg.green, st_reg.blue};
      ram_re          = 1'b0;
      ram_raddr       = st_reg.pal_addr;
      // palette word lands in the holding bytes
      if (st_reg.load_pend) begin
         {st_next.red, st_next.green, st_next.blue} = ram_rdata;
         st_next.load_pend = 1'b0;
      end
      // write side effects, taken at the end of the strobe
      if (wr_ev) begin
         case (s_sel)
            SEL_PAL_WADDR: begin
               st_next.pal_addr = s_din;
               st_next.mode     = PM_WRITE;
               st_next.comp     = COMP_RED;
            end
            SEL_PAL_DATA: begin
               if (st_reg.mode == PM_WRITE) begin
                  case (st_reg.comp)
                     COMP_RED: begin
                        st_next.red  = host_to_held(s_din, color_resolution_sel);
                        st_next.comp = COMP_GREEN;
                     end
                     COMP_GREEN: begin
                        st_next.green = host_to_held(s_din, color_resolution_sel);
                        st_next.comp  = COMP_BLUE;
                     end
                     COMP_BLUE: begin
                        st_next.blue     = host_to_held(s_din, color_resolution_sel);
                        ram_we           = 1'b1;
                        ram_wdata        = {st_reg.red, st_reg.green, st_next.blue};
                        st_next.pal_addr = addr_inc(st_reg.pal_addr);
                        st_next.comp     = COMP_RED;
                     end
                     default: begin
                        st_next.comp = COMP_RED;
                     end
                  endcase
               end
            end
            SEL_PIX_MASK: begin
               st_next.pix_mask = s_din;
            end
            SEL_PAL_RADDR: begin
               st_next.mode      = PM_READ;
               st_next.comp      = COMP_RED;
               ram_re            = 1'b1;
               ram_raddr         = s_din;
               st_next.load_pend = 1'b1;
               st_next.pal_addr  = addr_inc(s_din);
            end
            SEL_IDX_LOW: begin
               st_next.idx_ptr[DATA_W-1:0] = s_din;
            end
            SEL_IDX_HIGH: begin
               st_next.idx_ptr[IDX_W-1:DATA_W] = s_din[IDX_HI_W-1:0];
            end
            SEL_IDX_DATA: begin
               st_next.idx_wdata = s_din;
               st_next.idx_wr    = 1'b1;
            end
            SEL_IDX_CTL: begin
               st_next.idx_ctl = s_din;
            end
            default: begin
               st_next.idx_wr = 1'b0;
            end
         endcase
      end
      // read data, latched at the start of the strobe
      if (rd_begin) begin
         st_next.doe = 1'b1;
         case (s_sel)
            SEL_PAL_WADDR: st_next.dout = st_reg.pal_addr;
            SEL_PAL_DATA: begin
               case (st_reg.comp)
                  COMP_RED:   st_next.dout = held_to_host(st_reg.red, color_resolution_sel);
                  COMP_GREEN: st_next.dout = held_to_host(st_reg.green, color_resolution_sel);
                  default:    st_next.dout = held_to_host(st_reg.blue, color_resolution_sel);
               endcase
            end
            SEL_PIX_MASK:  st_next.dout = st_reg.pix_mask;
            SEL_PAL_RADDR: begin
               if (read_addr_status_fmt) begin
                  st_next.dout = (st_reg.mode == PM_READ) ? STATUS_READ : STATUS_WRITE;
               end else begin
                  st_next.dout = st_reg.pal_addr;
               end
            end
            SEL_IDX_LOW:   st_next.dout = st_reg.idx_ptr[DATA_W-1:0];
            SEL_IDX_HIGH:  st_next.dout = {{(DATA_W-IDX_HI_W){1'b0}}, st_reg.idx_ptr[IDX_W-1:DATA_W]};
            SEL_IDX_DATA:  st_next.dout = idx_rdata;
            SEL_IDX_CTL:   st_next.dout = st_reg.idx_ctl;
            default:       st_next.dout = BYTE_ZERO;
         endcase
      end
      // read side effects, taken at the end of the strobe
      if (rd_end) begin
         st_next.doe = 1'b0;
         if (s_sel == SEL_PAL_DATA && st_reg.mode == PM_READ) begin
            case (st_reg.comp)
               COMP_RED:   st_next.comp = COMP_GREEN;
               COMP_GREEN: st_next.comp = COMP_BLUE;
               default: begin
                  st_next.comp      = COMP_RED;
                  ram_re            = 1'b1;
                  st_next.load_pend = 1'b1;
                  st_next.pal_addr  = addr_inc(st_reg.pal_addr);
               end
            endcase
         end
         if (s_sel == SEL_IDX_DATA) begin
            st_next.idx_rd = 1'b1;
         end
      end
      // pointer steps after an indexed data access
      if ((wr_ev || rd_end) && s_sel == SEL_IDX_DATA && st_reg.idx_ctl[IDX_AUTOINC]) begin
         st_next.idx_ptr = st_reg.idx_ptr + IDX_STEP;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign host_data_out = st_reg.dout;
   assign host_data_oe  = st_reg.doe;
   assign pixel_mask    = st_reg.pix_mask;
   assign idx_addr      = st_reg.idx_ptr;
   assign idx_wdata     = st_reg.idx_wdata;
   assign idx_wr        = st_reg.idx_wr;
   assign idx_rd        = st_reg.idx_rd;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_third_write;
      wr_ev && s_sel == SEL_PAL_DATA && st_reg.mode == PM_WRITE && st_reg.comp == COMP_BLUE;
   endsequence

   sequence s_third_read;
      rd_end && s_sel == SEL_PAL_DATA && st_reg.mode == PM_READ && st_reg.comp == COMP_BLUE;
   endsequence

   a_scheme_indexed: assert property (
      wr_ev && s_sel[SCHEME_BIT] != SCHEME_VGA |=> $stable(st_reg.pal_addr) && $stable(st_reg.mode))
      else $error("indexed write disturbed palette state");

   a_write_mode_load: assert property (
      wr_ev && s_sel == SEL_PAL_WADDR |=> st_reg.mode == PM_WRITE && st_reg.pal_addr == $past(s_din)
         && st_reg.comp == COMP_RED)
      else $error("write-mode address load wrong");

   a_read_preload: assert property (
      wr_ev && s_sel == SEL_PAL_RADDR |=> st_reg.mode == PM_READ && st_reg.load_pend
         && st_reg.pal_addr == addr_inc($past(s_din)) ##1 !st_reg.load_pend)
      else $error("read-mode preload wrong");

   a_third_write_store: assert property (
      s_third_write |-> ram_we ##1 st_reg.pal_addr == addr_inc($past(st_reg.pal_addr))
         && st_reg.comp == COMP_RED)
      else $error("third data write did not store and step");

   a_third_read_load: assert property (
      s_third_read |-> ram_re ##1 st_reg.load_pend && st_reg.pal_addr == addr_inc($past(st_reg.pal_addr)))
      else $error("third data read did not reload and step");

   a_addr_wrap: assert property (
      s_third_write ##0 (&st_reg.pal_addr) |=> st_reg.pal_addr == BYTE_ZERO)
      else $error("palette address did not wrap");

   a_status_read: assert property (
      rd_begin && s_sel == SEL_PAL_RADDR && read_addr_status_fmt |=>
         st_reg.doe && st_reg.dout == ($past(st_reg.mode) == PM_READ ? STATUS_READ : STATUS_WRITE))
      else $error("status format read wrong");

   a_shared_addr: assert property (
      rd_begin && s_sel == SEL_PAL_WADDR |=> st_reg.dout == $past(st_reg.pal_addr))
      else $error("address read did not return shared address");

   a_sixbit_read: assert property (
      rd_begin && s_sel == SEL_PAL_DATA && color_resolution_sel == COLRES_6BIT |=> st_reg.dout[7:6] == 2'b00)
      else $error("six-bit read left upper bits set");

   a_mask_direct: assert property (
      wr_ev && s_sel == SEL_PIX_MASK |=> st_reg.pix_mask == $past(s_din) && $stable(st_reg.comp))
      else $error("pixel mask write wrong or disturbed sequence");

   a_index_step: assert property (
      (wr_ev || rd_end) && s_sel == SEL_IDX_DATA && st_reg.idx_ctl[IDX_AUTOINC] |=>
         st_reg.idx_ptr == $past(st_reg.idx_ptr) + IDX_STEP)
      else $error("index pointer did not step");

endmodule

//--- tb/hpap_host_model.sv
// host cpu model driving the select, strobe and data pins
// assumes mclk from the bench; strobes idle high between cycles
`timescale 1ns/1ps
module hpap_host_model (
   input  wire logic       mclk,
   output logic [2:0]      reg_select,
   output logic            host_wr_n,
   output logic            host_rd_n,
   output logic [7:0]      host_data_in,
   input  wire logic [7:0] host_data_out,
   input  wire logic       host_data_oe
);
   initial begin
      reg_select = 3'h0;
      host_wr_n = 1'b1;
      host_rd_n = 1'b1;
      host_data_in = 8'h00;
   end
   // wait n edges, then step just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // write: select/data settle 2 cycles ahead, strobe low 4 cycles
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      cyc(1);
      reg_select = s;
      host_data_in = d;
      cyc(2);
      host_wr_n = 1'b0;
      cyc(4);
      host_wr_n = 1'b1;
      cyc(4);
      host_data_in = ~d; // released bus no longer shows the byte
   endtask
   // read: data valid 3 edges after the strobe falls, drive enable taken with it
   task automatic rd(input logic [2:0] s, output logic [7:0] d, output logic e);
      cyc(1);
      reg_select = s;
      cyc(2);
      host_rd_n = 1'b0;
      cyc(4);
      d = host_data_out;
      e = host_data_oe;
      host_rd_n = 1'b1;
      cyc(4);
   endtask
endmodule

//--- tb/tb_hpap_host_port.sv
// self-checking bench for the host palette access port
// assumes the host model drives pins and a stub indexed file answers
`timescale 1ns/1ps
module tb_hpap_host_port;
   import hpap_pkg::*;
   logic        mclk = 1'b0, nrst = 1'b0, res = 1'b1, fmt = 1'b0;
   logic [7:0]  pix_idx = 8'h00, pa, sel_d, din, dout, mask, idx_wd, wd;
   logic [2:0]  sel;
   logic        wr_n, rd_n, oe, idx_wr, idx_rd;
   logic [23:0] pix_col, pal [256];   // palette model
   logic [10:0] idx_a;
   logic [31:0] lfsr = 32'd73501;
   int          err_total = 0;
   int          checks_done = 0;
   int          rd_pulses = 0;        // indexed read pulses seen
   always #12.5 mclk = ~mclk;
   hpap_host_model HOST (.mclk(mclk), .reg_select(sel), .host_wr_n(wr_n), .host_rd_n(rd_n),
      .host_data_in(din), .host_data_out(dout), .host_data_oe(oe));
   hpap_host_port DUT (.mclk(mclk), .nrst(nrst), .reg_select(sel), .host_wr_n(wr_n),
      .host_rd_n(rd_n), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
      .color_resolution_sel(res), .read_addr_status_fmt(fmt), .pixel_mask(mask),
      .pixel_index(pix_idx), .pixel_color(pix_col), .idx_addr(idx_a), .idx_wdata(idx_wd),
      .idx_wr(idx_wr), .idx_rd(idx_rd), .idx_rdata(idx_a[7:0] ^ 8'h5A));
   // capture indexed write byte
   always @(posedge mclk) if (idx_wr === 1'b1) wd <= idx_wd;
   // count indexed read pulses, one per finished indexed data read
   always @(posedge mclk) if (idx_rd === 1'b1) rd_pulses++;
   // next value of the stimulus shift register
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic rnd;
      lfsr = lfsr_next(lfsr);
   endtask
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [2:0] s, input logic [7:0] e);
      logic [7:0] v;
      logic       o;
      HOST.rd(s, v, o);
      chk(v, e);
      chk(o, 1'b1);
      chk(oe, 1'b0);
   endtask
   // write-mode address n, then k random entries
   task automatic fill(input logic [7:0] n, input int k);
      HOST.wr(SEL_PAL_WADDR, n);
      pa = n;
      repeat (k) begin
         for (int i = 0; i < 3; i++) begin
            rnd;
            HOST.wr(SEL_PAL_DATA, lfsr[7:0]);
            pal[pa][23-8*i -: 8] = res ? lfsr[7:0] : {lfsr[5:0], 2'b00};
         end
         pa++;
      end
   endtask
   // read-mode address n, then k entries byte by byte
   task automatic drain(input logic [7:0] n, input int k);
      HOST.wr(SEL_PAL_RADDR, n);
      pa = n;
      repeat (k) begin
         for (int i = 0; i < 3; i++) begin
            sel_d = pal[pa][23-8*i -: 8];
            rdc(SEL_PAL_DATA, res ? sel_d : {2'b00, sel_d[7:2]});
         end
         pa++;
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      print_verdict;
   end
   initial begin
      HOST.cyc(3);
      nrst = 1'b1;
      HOST.cyc(2);
      rdc(SEL_PIX_MASK, 8'hFF);
      rnd;
      HOST.wr(SEL_PIX_MASK, lfsr[7:0]);
      chk(mask, lfsr[7:0]);
      rdc(SEL_PIX_MASK, lfsr[7:0]);
      fill(8'hFE, 2);
      rdc(SEL_PAL_WADDR, 8'h00);
      rdc(SEL_PAL_RADDR, 8'h00);
      drain(8'hFE, 2);
      rdc(SEL_PAL_WADDR, 8'h01);
      pix_idx = 8'hFF;
      HOST.cyc(3);
      chk(pix_col, pal[255]);
      HOST.wr(SEL_PAL_WADDR, 8'h20);
      HOST.wr(SEL_PAL_DATA, 8'hAA);
      fill(8'h20, 1);
      drain(8'h20, 1);
      res = 1'b0;
      fill(8'h40, 1);
      drain(8'h40, 1);
      fmt = 1'b1;
      rdc(SEL_PAL_RADDR, STATUS_READ);
      HOST.wr(SEL_PAL_WADDR, 8'h00);
      rdc(SEL_PAL_RADDR, STATUS_WRITE);
      fmt = 1'b0;
      HOST.wr(SEL_IDX_CTL, 8'h01);
      HOST.wr(SEL_IDX_LOW, 8'h34);
      HOST.wr(SEL_IDX_HIGH, 8'hFA);
      rdc(SEL_IDX_HIGH, 8'h02);
      rdc(SEL_IDX_CTL, 8'h01);
      rnd;
      HOST.wr(SEL_IDX_DATA, lfsr[7:0]);
      chk(wd, lfsr[7:0]);
      rdc(SEL_IDX_DATA, 8'h35 ^ 8'h5A);
      chk(idx_a, 11'h236);
      chk(24'(rd_pulses), 24'h000001);
      rdc(SEL_IDX_LOW, 8'h36);
      // mid-run reset, then reset values again
      nrst = 1'b0;
      HOST.cyc(3);
      nrst = 1'b1;
      HOST.cyc(1);
      chk(mask, PIX_MASK_RST);
      chk(idx_a, IDX_RST);
      chk(dout, BYTE_ZERO);
      rdc(SEL_PAL_WADDR, PAL_ADDR_RST);
      print_verdict;
   end
endmodule
